// file: rtl/cpf_pkg.sv
// package for the processor flags block: address, bit positions, reset value, operation codes
// assumes one instruction-cycle clock shared by the datapath and the watchdog logic
package cpf_pkg;
    localparam logic [4:0] CPF_FLAGS_ADDR = 5'h03;
    localparam int CPF_BIT_CARRY = 0;
    localparam int CPF_BIT_NIBBLE = 1;
    localparam int CPF_BIT_ZERO = 2;
    localparam int CPF_BIT_SLEEP = 3;
    localparam int CPF_BIT_EXPIRY = 4;
    localparam int CPF_BIT_BANK_LO = 5;
    localparam int CPF_BIT_BANK_HI = 6;
    localparam int CPF_BIT_UPPER = 7;
    localparam logic [7:0] CPF_FLAGS_RESET = 8'h18;
    localparam int CPF_PAGE_ADDR_BITS = 9;
    localparam logic [8:0] CPF_PAGE_OFFSET_ZERO = 9'h000;

    typedef enum logic [3:0] {
        CPF_OP_NONE = 4'h0,
        CPF_OP_MOVE = 4'h1,
        CPF_OP_LOGIC = 4'h2,
        CPF_OP_ADD = 4'h3,
        CPF_OP_SUB = 4'h4,
        CPF_OP_ROT_LEFT = 4'h5,
        CPF_OP_ROT_RIGHT = 4'h6,
        CPF_OP_CLEAR = 4'h7,
        CPF_OP_KICK = 4'h8,
        CPF_OP_SLEEP = 4'h9
    } cpf_op_t;
endpackage

// file: rtl/cpf_alu_flags.sv
// result and flag logic of one instruction: sum, difference, rotates, clear, pass-through
// assumes operands are stable for the cycle in which the instruction executes
`timescale 1ns/1ns
`default_nettype none
module cpf_alu_flags (
    input wire cpf_pkg::cpf_op_t op,
    input wire logic [7:0] fileVal,
    input wire logic [7:0] workVal,
    input wire logic [7:0] dataIn,
    input wire logic carryIn,
    output logic [7:0] res,
    output logic zeroOut,
    output logic nibbleOut,
    output logic carryOut,
    output logic affZero,
    output logic affNibble,
    output logic affCarry
);
    import cpf_pkg::*;

    logic [8:0] sum;
    logic [4:0] lowSum;
    logic [7:0] addend;
    logic addCin;

    always_comb begin
        // subtract is file plus inverted working plus one, so carry means no borrow
        addend = (op == CPF_OP_SUB) ? ~workVal : workVal;
        addCin = (op == CPF_OP_SUB);
        sum = {1'b0, fileVal} + {1'b0, addend} + {8'h00, addCin};
        lowSum = {1'b0, fileVal[3:0]} + {1'b0, addend[3:0]} + {4'h0, addCin};
        res = dataIn;
        nibbleOut = 1'b0;
        carryOut = carryIn;
        affZero = 1'b0;
        affNibble = 1'b0;
        affCarry = 1'b0;
        case (op)
            CPF_OP_ADD, CPF_OP_SUB: begin
                res = sum[7:0];
                nibbleOut = lowSum[4];
                carryOut = sum[8];
                affZero = 1'b1;
                affNibble = 1'b1;
                affCarry = 1'b1;
            end
            CPF_OP_ROT_LEFT: begin
                res = {fileVal[6:0], carryIn};
                carryOut = fileVal[7];
                affCarry = 1'b1;
            end
            CPF_OP_ROT_RIGHT: begin
                res = {carryIn, fileVal[7:1]};
                carryOut = fileVal[0];
                affCarry = 1'b1;
            end
            CPF_OP_LOGIC: begin
                affZero = 1'b1;
            end
            CPF_OP_CLEAR: begin
                res = 8'h00;
                affZero = 1'b1;
            end
            default: begin
                res = dataIn;
            end
        endcase
        zeroOut = (res == 8'h00);
    end
endmodule // cpf_alu_flags
`default_nettype wire

// file: rtl/cpf_status_flags.sv
// processor flags register: arithmetic flags, reset-cause flags, program page preselect
// assumes execValid and watchdogExpire come from logic on the same instruction clock
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - the flags register can be any instruction's destination like a file register
// - instructions updating zero, nibble or carry flags drop data writes to those bits
// - writes to watchdog expiry and sleep flags are ignored; only events change them
// - clearing the flags register zeroes bits 7:5 (upper bank and page bits), sets zero, keeps the rest
// - page bits 6:5 select one of four 512-word program pages, 00 lowest
// - expiry flag set at power-up, watchdog kick, sleep; cleared on watchdog expiry
// - nibble carry set on carry out of low nibble; for subtract set means no borrow
// - carry driven by add, subtract, rotate; subtract carry zero means borrow
module cpf_status_flags (
    input wire logic clock,
    input wire logic resetn,
    input wire logic execValid,
    input wire cpf_pkg::cpf_op_t execOp,
    input wire logic destIsFile,
    input wire logic [4:0] destAddr,
    input wire logic [7:0] fileVal,
    input wire logic [7:0] workVal,
    input wire logic [7:0] dataIn,
    input wire logic watchdogExpire,
    output logic [7:0] resultData,
    output logic resultValid,
    output logic [7:0] flagsRead,
    output logic [10:0] pageBase,
    output logic upper_bank_choice
);
    import cpf_pkg::*;

    logic [7:0] flags_q, flags_d;
    logic [7:0] result_q, result_d;
    logic valid_q, valid_d;
    logic [7:0] aluRes;
    logic zeroNew, nibbleNew, carryNew;
    logic affZero, affNibble, affCarry;
    logic hitFlags;

    cpf_alu_flags u_alu (
        .op(execOp),
        .fileVal(fileVal),
        .workVal(workVal),
        .dataIn(dataIn),
        .carryIn(flags_q[CPF_BIT_CARRY]),
        .res(aluRes),
        .zeroOut(zeroNew),
        .nibbleOut(nibbleNew),
        .carryOut(carryNew),
        .affZero(affZero),
        .affNibble(affNibble),
        .affCarry(affCarry)
    );

    // writes land here when the destination is the flags address
    assign hitFlags = execValid && destIsFile && (destAddr == CPF_FLAGS_ADDR);

    always_comb begin
        flags_d = flags_q;
        result_d = result_q;
        valid_d = 1'b0;
        if (execValid) begin
            result_d = aluRes;
            valid_d = (execOp != CPF_OP_NONE) && (execOp != CPF_OP_KICK) && (execOp != CPF_OP_SLEEP);
            if (hitFlags && valid_d) begin
                // upper-bank and page bits take the data like any file register
                flags_d[CPF_BIT_UPPER] = aluRes[CPF_BIT_UPPER];
                flags_d[CPF_BIT_BANK_HI] = aluRes[CPF_BIT_BANK_HI];
                flags_d[CPF_BIT_BANK_LO] = aluRes[CPF_BIT_BANK_LO];
                // data write to the low three is disabled for flag-affecting ops
                if (!(affZero || affNibble || affCarry)) begin
                    flags_d[CPF_BIT_ZERO] = aluRes[CPF_BIT_ZERO];
                    flags_d[CPF_BIT_NIBBLE] = aluRes[CPF_BIT_NIBBLE];
                    flags_d[CPF_BIT_CARRY] = aluRes[CPF_BIT_CARRY];
                end
                // expiry and sleep bits are never taken from data
            end
            if (affZero) begin
                flags_d[CPF_BIT_ZERO] = zeroNew;
            end
            if (affNibble) begin
                flags_d[CPF_BIT_NIBBLE] = nibbleNew;
            end
            if (affCarry) begin
                flags_d[CPF_BIT_CARRY] = carryNew;
            end
            if (execOp == CPF_OP_KICK) begin
                flags_d[CPF_BIT_EXPIRY] = 1'b1;
                flags_d[CPF_BIT_SLEEP] = 1'b1;
            end
            if (execOp == CPF_OP_SLEEP) begin
                flags_d[CPF_BIT_EXPIRY] = 1'b1;
                flags_d[CPF_BIT_SLEEP] = 1'b0;
            end
        end
        // an expiry in the same cycle as a kick or sleep wins
        if (watchdogExpire) begin
            flags_d[CPF_BIT_EXPIRY] = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flags_q <= CPF_FLAGS_RESET;
            result_q <= 8'h00;
            valid_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            result_q <= result_d;
            valid_q <= valid_d;
        end
    end

    assign flagsRead = flags_q;
    assign resultData = result_q;
    assign resultValid = valid_q;
    assign upper_bank_choice = flags_q[CPF_BIT_UPPER];
    // page code picks a 512-word page: base address is code times 512
    assign pageBase = {flags_q[CPF_BIT_BANK_HI], flags_q[CPF_BIT_BANK_LO], CPF_PAGE_OFFSET_ZERO};

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    logic hitPast;
    assign hitPast = hitFlags;

    property p_store_writes_flags;
        hitFlags && execOp == CPF_OP_MOVE |=> flagsRead[7:5] == $past(dataIn[7:5])
            && flagsRead[2:0] == $past(dataIn[2:0]);
    endproperty
    a_store_writes_flags: assert property (p_store_writes_flags) else $error("store to flags lost data");

    property p_add_drops_write;
        hitFlags && execOp == CPF_OP_ADD |=> flagsRead[CPF_BIT_CARRY] == $past(carryNew)
            && flagsRead[CPF_BIT_NIBBLE] == $past(nibbleNew);
    endproperty
    a_add_drops_write: assert property (p_add_drops_write) else $error("add to flags took data bits");

    property p_event_bits_no_write;
        hitFlags && execOp == CPF_OP_MOVE && !watchdogExpire |=> flagsRead[4:3] == $past(flagsRead[4:3]);
    endproperty
    a_event_bits_no_write: assert property (p_event_bits_no_write) else $error("event bits written by data");

    property p_clear_flags;
        hitFlags && execOp == CPF_OP_CLEAR && !watchdogExpire |=>
            flagsRead[7:5] == 3'h0 && flagsRead[CPF_BIT_ZERO]
            && flagsRead[4:3] == $past(flagsRead[4:3]) && flagsRead[1:0] == $past(flagsRead[1:0]);
    endproperty
    a_clear_flags: assert property (p_clear_flags) else $error("clear of flags register wrong");

    property p_page_base;
        pageBase[10:9] == flagsRead[6:5] && pageBase[8:0] == 9'h000;
    endproperty
    a_page_base: assert property (p_page_base) else $error("page base mismatch");

    property p_expiry_events;
        (watchdogExpire |=> !flagsRead[CPF_BIT_EXPIRY])
        and (execValid && execOp == CPF_OP_SLEEP && !watchdogExpire |=> flagsRead[CPF_BIT_EXPIRY]);
    endproperty
    a_expiry_events: assert property (p_expiry_events) else $error("expiry flag wrong");

    property p_sub_nibble;
        execValid && execOp == CPF_OP_SUB |=>
            flagsRead[CPF_BIT_NIBBLE] == ($past(fileVal[3:0]) >= $past(workVal[3:0]))
            && flagsRead[CPF_BIT_CARRY] == ($past(fileVal) >= $past(workVal));
    endproperty
    a_sub_nibble: assert property (p_sub_nibble) else $error("subtract borrow flags wrong");

    property p_sleep_flag;
        execValid && (execOp == CPF_OP_SLEEP || execOp == CPF_OP_KICK) |=>
            flagsRead[CPF_BIT_SLEEP] == ($past(execOp) == CPF_OP_KICK);
    endproperty
    a_sleep_flag: assert property (p_sleep_flag) else $error("sleep flag wrong");

    property p_zero_flag;
        execValid && execOp == CPF_OP_LOGIC |=> flagsRead[CPF_BIT_ZERO] == ($past(dataIn) == 8'h00)
            && resultValid ##1 !resultValid || $past(execValid);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

    property p_rotate_carry;
        execValid && execOp == CPF_OP_ROT_LEFT |=> flagsRead[CPF_BIT_CARRY] == $past(fileVal[7]);
    endproperty
    a_rotate_carry: assert property (p_rotate_carry) else $error("rotate carry wrong");

    c_clear_flags: cover property (hitPast && execOp == CPF_OP_CLEAR);
    c_add_to_flags: cover property (hitPast && execOp == CPF_OP_ADD);
    c_expiry_then_kick: cover property (watchdogExpire ##[1:20] execValid && execOp == CPF_OP_KICK);
endmodule // cpf_status_flags
`default_nettype wire

// file: bench/cpf_exec_model.sv
// partner model: instruction datapath and watchdog logic that feed the flags block
// assumes the bench calls run() from a single process, one instruction at a time
`timescale 1ns/1ns
`default_nettype none
module cpf_exec_model (
    input wire logic clock,
    output logic execValid,
    output cpf_pkg::cpf_op_t execOp,
    output logic destIsFile,
    output logic [4:0] destAddr,
    output logic [7:0] fileVal,
    output logic [7:0] workVal,
    output logic [7:0] dataIn,
    output logic watchdogExpire
);
    import cpf_pkg::*;

    initial begin
        execValid = 1'b0;
        execOp = CPF_OP_NONE;
        destIsFile = 1'b0;
        destAddr = 5'h00;
        fileVal = 8'h00;
        workVal = 8'h00;
        dataIn = 8'h00;
        watchdogExpire = 1'b0;
    end

    // page bits only ever carry page numbers; plain flag edits use the store op
    // one instruction or watchdog pulse for one cycle; operands are scrambled once released
    task automatic run(input cpf_op_t op, input int v, input int isFile, input logic [4:0] a,
                       input logic [7:0] f, input logic [7:0] w, input logic [7:0] d, input int wd);
        @(posedge clock);
        execValid <= (v != 0);
        execOp <= op;
        destIsFile <= (isFile != 0);
        destAddr <= a;
        fileVal <= f;
        workVal <= w;
        dataIn <= d;
        watchdogExpire <= (wd != 0);
        @(posedge clock);
        execValid <= 1'b0;
        watchdogExpire <= 1'b0;
        fileVal <= ~f;
        workVal <= ~w;
        dataIn <= ~d;
        #1;
    endtask
endmodule // cpf_exec_model
`default_nettype wire

// file: bench/cpf_status_flags_bench.sv
// self-checking bench for the processor flags block
// assumes the exec model drives every datapath input of the block
`timescale 1ns/1ns
`default_nettype none
module cpf_status_flags_bench;
    import cpf_pkg::*;
    logic clock, resetn, execValid, destIsFile, watchdogExpire, resultValid, upperBank;
    cpf_op_t execOp;
    logic [4:0] destAddr;
    logic [7:0] fileVal, workVal, dataIn, resultData, flagsRead;
    logic [10:0] pageBase;
    int err_total = 0;
    int num_checks = 0;
    localparam logic [4:0] FA = CPF_FLAGS_ADDR;

    initial clock = 1'b0;
    always #50 clock = ~clock;

    cpf_exec_model u_model (.clock(clock), .execValid(execValid), .execOp(execOp), .destIsFile(destIsFile),
        .destAddr(destAddr), .fileVal(fileVal), .workVal(workVal), .dataIn(dataIn),
        .watchdogExpire(watchdogExpire));
    cpf_status_flags u_dut (.clock(clock), .resetn(resetn), .execValid(execValid), .execOp(execOp),
        .destIsFile(destIsFile), .destAddr(destAddr), .fileVal(fileVal), .workVal(workVal), .dataIn(dataIn),
        .watchdogExpire(watchdogExpire), .resultData(resultData), .resultValid(resultValid),
        .flagsRead(flagsRead), .pageBase(pageBase), .upper_bank_choice(upperBank));

    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        err_total++;
        conclude();
    end

    initial begin
        resetn = 1'b0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        #1;
        chk(flagsRead, 8'h18);
        chk(pageBase, 11'h000);
        $display("test reset done");
        u_model.run(CPF_OP_MOVE, 1, 1, FA, 8'h00, 8'h00, 8'h67, 0);
        chk(flagsRead, 8'h7f);
        chk(resultValid, 1'b1);
        chk(pageBase, 11'h600);
        u_model.run(CPF_OP_MOVE, 1, 1, 5'h10, 8'h00, 8'h00, 8'h00, 0);
        chk(flagsRead, 8'h7f);
        $display("test store done");
        for (int p = 0; p < 4; p++) begin
            u_model.run(CPF_OP_MOVE, 1, 1, FA, 8'h00, 8'h00, {1'b1, 2'(p), 5'h00}, 0);
            chk(flagsRead, {3'h0, 1'b1, 2'(p), 5'h18});
            chk(pageBase, {2'(p), 9'h000});
            chk(upperBank, 1'b1);
        end
        $display("test pages done");
        u_model.run(CPF_OP_ADD, 1, 1, FA, 8'h0f, 8'h01, 8'hff, 0);
        chk(flagsRead, 8'h1a);
        chk(resultData, 8'h10);
        u_model.run(CPF_OP_SUB, 1, 0, FA, 8'h05, 8'h05, 8'h00, 0);
        chk(flagsRead, 8'h1f);
        u_model.run(CPF_OP_SUB, 1, 0, FA, 8'h00, 8'h01, 8'h00, 0);
        chk(flagsRead, 8'h18);
        chk(resultData, 8'hff);
        u_model.run(CPF_OP_ROT_LEFT, 1, 0, FA, 8'h80, 8'h00, 8'h00, 0);
        chk(flagsRead, 8'h19);
        $display("test arithmetic done");
        u_model.run(CPF_OP_MOVE, 1, 1, FA, 8'h00, 8'h00, 8'hff, 0);
        chk(flagsRead, 8'hff);
        u_model.run(CPF_OP_CLEAR, 1, 1, FA, 8'h00, 8'h00, 8'hff, 0);
        chk(flagsRead, 8'h1f);
        $display("test clear done");
        u_model.run(CPF_OP_NONE, 0, 0, FA, 8'h00, 8'h00, 8'h00, 1);
        chk(flagsRead, 8'h0f);
        u_model.run(CPF_OP_SLEEP, 1, 0, FA, 8'h00, 8'h00, 8'h00, 0);
        chk(flagsRead, 8'h17);
        u_model.run(CPF_OP_KICK, 1, 0, FA, 8'h00, 8'h00, 8'h00, 0);
        chk(flagsRead, 8'h1f);
        u_model.run(CPF_OP_KICK, 1, 0, FA, 8'h00, 8'h00, 8'h00, 1);
        chk(flagsRead, 8'h0f);
        u_model.run(CPF_OP_LOGIC, 1, 1, FA, 8'h00, 8'h00, 8'he3, 0);
        chk(flagsRead, 8'heb);
        $display("test events done");
        @(posedge clock);
        resetn <= 1'b0;
        #1;
        chk(flagsRead, 8'h18);
        chk(pageBase, 11'h000);
        @(posedge clock);
        resetn <= 1'b1;
        #1;
        chk(flagsRead, 8'h18);
        u_model.run(CPF_OP_ROT_RIGHT, 1, 1, FA, 8'h01, 8'h00, 8'hff, 0);
        chk(flagsRead, 8'h19);
        chk(resultData, 8'h00);
        chk(resultValid, 1'b1);
        u_model.run(CPF_OP_ADD, 1, 0, FA, 8'hff, 8'h01, 8'h00, 0);
        chk(flagsRead, 8'h1f);
        @(posedge clock);
        #1;
        chk(resultValid, 1'b0);
        $display("test second reset done");
        conclude();
    end
endmodule // cpf_status_flags_bench
`default_nettype wire
